/* File: hdl/crs_pkg.sv */
`default_nettype none
package crs_pkg;

	// Register selects; APB byte address is select times four
	localparam logic [4:0] SEL_DATA0     = 5'h00;
	localparam logic [4:0] SEL_DATA1     = 5'h01;
	localparam logic [4:0] SEL_DATA2     = 5'h02;
	localparam logic [4:0] SEL_DATA3     = 5'h03;
	localparam logic [4:0] SEL_ADDR0     = 5'h04;
	localparam logic [4:0] SEL_ADDR1     = 5'h05;
	localparam logic [4:0] SEL_FRAME     = 5'h06;
	localparam logic [4:0] SEL_VECT      = 5'h07;
	localparam logic [4:0] SEL_PC        = 5'h08;
	localparam logic [4:0] SEL_USP       = 5'h09;
	localparam logic [4:0] SEL_ISP       = 5'h0A;
	localparam logic [4:0] SEL_STATIC    = 5'h0B;
	localparam logic [4:0] SEL_FLAGS     = 5'h0C;
	localparam logic [4:0] SEL_D0_LOW    = 5'h0D;
	localparam logic [4:0] SEL_D0_HIGH   = 5'h0E;
	localparam logic [4:0] SEL_D1_LOW    = 5'h0F;
	localparam logic [4:0] SEL_D1_HIGH   = 5'h10;
	localparam logic [4:0] SEL_PAIR_D0   = 5'h11;
	localparam logic [4:0] SEL_PAIR_D1   = 5'h12;
	localparam logic [4:0] SEL_PAIR_A    = 5'h13;
	localparam logic [4:0] SEL_SP        = 5'h14;
	localparam logic [4:0] SEL_LAST      = 5'h14;

	// APB address layout
	localparam int         ADDR_W        = 12;
	localparam int         SEL_LSB       = 2;

	// Flag bit positions
	localparam int         FLG_W         = 11;
	localparam int         FLG_C         = 0;
	localparam int         FLG_D         = 1;
	localparam int         FLG_Z         = 2;
	localparam int         FLG_S         = 3;
	localparam int         FLG_B         = 4;
	localparam int         FLG_O         = 5;
	localparam int         FLG_U         = 7;

	// Operand sizes for flag evaluation
	localparam logic [1:0] SIZE_BYTE     = 2'h0;
	localparam logic [1:0] SIZE_WORD     = 2'h1;

	// Reset values
	localparam logic [15:0] RST_WORD     = 16'h0000;
	localparam logic [19:0] RST_LONG     = 20'h0_0000;
	localparam logic [10:0] RST_FLG      = 11'h000;

	// Select decode shared by bus and core
	function automatic logic crs_sel_ok(input logic [4:0] sel);
		crs_sel_ok = (sel <= SEL_LAST);
	endfunction

	// Zero test at the operation's size
	function automatic logic crs_is_zero(input logic [31:0] r,
		input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: crs_is_zero = (r[7:0] == 8'h00);
			SIZE_WORD: crs_is_zero = (r[15:0] == 16'h0000);
			default:   crs_is_zero = (r == 32'h0000_0000);
		endcase
	endfunction

	// Sign bit at the operation's size
	function automatic logic crs_is_neg(input logic [31:0] r,
		input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: crs_is_neg = r[7];
			SIZE_WORD: crs_is_neg = r[15];
			default:   crs_is_neg = r[31];
		endcase
	endfunction

endpackage
`default_nettype wire

/* File: hdl/crs_core_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module crs_core_regs
	import crs_pkg::*;
(
	input  wire logic        MCLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	input  wire logic [3:0]  PSTRB_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        EX_WR_EN_I,
	input  wire logic [4:0]  EX_WR_SEL_I,
	input  wire logic [31:0] EX_WR_DATA_I,
	input  wire logic [4:0]  EX_RD_SEL_I,
	output logic      [31:0] EX_RD_DATA_O,
	input  wire logic        ALU_FLAG_EN_I,
	input  wire logic [1:0]  ALU_SIZE_I,
	input  wire logic [31:0] ALU_RESULT_I,
	input  wire logic        ALU_CARRY_EN_I,
	input  wire logic        ALU_CARRY_I,
	input  wire logic        ALU_OVF_EN_I,
	input  wire logic        ALU_OVF_I,
	input  wire logic        PC_STEP_EN_I,
	input  wire logic [2:0]  PC_STEP_I,
	output logic      [15:0] ACTIVE_SP_O,
	output logic      [19:0] PC_O,
	output logic      [19:0] VECT_BASE_O,
	output logic      [15:0] FRAME_BASE_O,
	output logic      [15:0] STATIC_BASE_O,
	output logic      [10:0] FLAGS_O
);

	// Banked storage: two copies of data, address and frame words
	logic [15:0] dreg  [2][4];
	logic [15:0] areg  [2][2];
	logic [15:0] fbreg [2];
	logic [15:0] user_stack_pointer;
	logic [15:0] interrupt_stack_pointer;
	logic [15:0] sb;
	logic [19:0] vector_table_base;
	logic [19:0] pc;
	logic [10:0] cpu_flags;
	logic        bank;

	// Current-bank views
	logic [15:0] cur_d [4];
	logic [15:0] cur_a [2];

	// Write ports: 0 is the bus, 1 is execution (later one wins)
	logic        wr_en   [2];
	logic [4:0]  wr_sel  [2];
	logic [31:0] wr_data [2];

	// Bus decode
	logic [4:0]  apb_sel;
	logic        apb_ok;
	logic        apb_done;
	logic        apb_wr;
	logic [31:0] apb_mask;
	logic [31:0] apb_wdata;

	assign bank = cpu_flags[FLG_B];

	// Accesses are steered to the bank the flag selects
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cur_d[i] = dreg[bank][i];
		end
		for (int i = 0; i < 2; i++) begin
			cur_a[i] = areg[bank][i];
		end
	end

	// Read view of every select, shared by bus, core and write merge
	function automatic logic [31:0] rd_val(input logic [4:0] sel);
		case (sel)
			SEL_DATA0:   rd_val = {16'h0000, cur_d[0]};
			SEL_DATA1:   rd_val = {16'h0000, cur_d[1]};
			SEL_DATA2:   rd_val = {16'h0000, cur_d[2]};
			SEL_DATA3:   rd_val = {16'h0000, cur_d[3]};
			SEL_ADDR0:   rd_val = {16'h0000, cur_a[0]};
			SEL_ADDR1:   rd_val = {16'h0000, cur_a[1]};
			SEL_FRAME:   rd_val = {16'h0000, fbreg[bank]};
			SEL_VECT:    rd_val = {12'h000, vector_table_base};
			SEL_PC:      rd_val = {12'h000, pc};
			SEL_USP:     rd_val = {16'h0000, user_stack_pointer};
			SEL_ISP:     rd_val = {16'h0000, interrupt_stack_pointer};
			SEL_STATIC:  rd_val = {16'h0000, sb};
			SEL_FLAGS:   rd_val = {21'h00_0000, cpu_flags};
			SEL_D0_LOW:  rd_val = {24'h00_0000, cur_d[0][7:0]};
			SEL_D0_HIGH: rd_val = {24'h00_0000, cur_d[0][15:8]};
			SEL_D1_LOW:  rd_val = {24'h00_0000, cur_d[1][7:0]};
			SEL_D1_HIGH: rd_val = {24'h00_0000, cur_d[1][15:8]};
			SEL_PAIR_D0: rd_val = {cur_d[2], cur_d[0]};
			SEL_PAIR_D1: rd_val = {cur_d[3], cur_d[1]};
			SEL_PAIR_A:  rd_val = {cur_a[1], cur_a[0]};
			SEL_SP:      rd_val = {16'h0000, cpu_flags[FLG_U] ? user_stack_pointer : interrupt_stack_pointer};
			default:     rd_val = 32'h0000_0000;
		endcase
	endfunction

	// Bus address decode; misaligned or out-of-range is an error
	assign apb_sel  = PADDR_I[SEL_LSB +: 5];
	assign apb_ok   = (PADDR_I[1:0] == 2'h0) && (PADDR_I[11:7] == 5'h00)
		&& crs_sel_ok(apb_sel);
	assign apb_done = PSEL_I && PENABLE_I && PREADY_O;
	assign apb_wr   = apb_done && PWRITE_I && apb_ok;

	// Byte strobes merge new lanes over the current contents
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			apb_mask[i*8 +: 8] = {8{PSTRB_I[i]}};
		end
		apb_wdata = (PWDATA_I & apb_mask) | (rd_val(apb_sel) & ~apb_mask);
	end

	// Execution writes land after the bus, so the core wins a collision
	always_comb begin
		wr_en[0]   = apb_wr;
		wr_sel[0]  = apb_sel;
		wr_data[0] = apb_wdata;
		wr_en[1]   = EX_WR_EN_I && crs_sel_ok(EX_WR_SEL_I);
		wr_sel[1]  = EX_WR_SEL_I;
		wr_data[1] = EX_WR_DATA_I;
	end

	// APB slave: one wait state, then a one-cycle ready
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PREADY_O  <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
			if (PSEL_I && PENABLE_I && !PREADY_O) begin
				PRDATA_O  <= (!PWRITE_I && apb_ok) ? rd_val(apb_sel)
					: 32'h0000_0000;
				PSLVERR_O <= !apb_ok;
			end else if (apb_done) begin
				PSLVERR_O <= 1'b0;
			end
		end
	end

	// Banked data, address and frame words
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < 4; i++) begin
					dreg[b][i] <= RST_WORD;
				end
				areg[b][0] <= RST_WORD;
				areg[b][1] <= RST_WORD;
				fbreg[b]   <= RST_WORD;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (wr_en[p]) begin
					case (wr_sel[p])
						SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3:
							dreg[bank][wr_sel[p][1:0]] <= wr_data[p][15:0];
						SEL_ADDR0, SEL_ADDR1:
							areg[bank][wr_sel[p][0]] <= wr_data[p][15:0];
						SEL_FRAME:
							fbreg[bank] <= wr_data[p][15:0];
						SEL_D0_LOW:
							dreg[bank][0][7:0] <= wr_data[p][7:0];
						SEL_D0_HIGH:
							dreg[bank][0][15:8] <= wr_data[p][7:0];
						SEL_D1_LOW:
							dreg[bank][1][7:0] <= wr_data[p][7:0];
						SEL_D1_HIGH:
							dreg[bank][1][15:8] <= wr_data[p][7:0];
						SEL_PAIR_D0: begin
							dreg[bank][2] <= wr_data[p][31:16];
							dreg[bank][0] <= wr_data[p][15:0];
						end
						SEL_PAIR_D1: begin
							dreg[bank][3] <= wr_data[p][31:16];
							dreg[bank][1] <= wr_data[p][15:0];
						end
						SEL_PAIR_A: begin
							areg[bank][1] <= wr_data[p][31:16];
							areg[bank][0] <= wr_data[p][15:0];
						end
						default: ;
					endcase
				end
			end
		end
	end

	// Unbanked bases and stack pointers
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			user_stack_pointer  <= RST_WORD;
			interrupt_stack_pointer  <= RST_WORD;
			sb   <= RST_WORD;
			vector_table_base <= RST_LONG;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (wr_en[p]) begin
					case (wr_sel[p])
						SEL_VECT:   vector_table_base <= wr_data[p][19:0];
						SEL_USP:    user_stack_pointer  <= wr_data[p][15:0];
						SEL_ISP:    interrupt_stack_pointer  <= wr_data[p][15:0];
						SEL_STATIC: sb   <= wr_data[p][15:0];
						SEL_SP: begin
							// Active pointer alias follows the stack-select flag
							if (cpu_flags[FLG_U]) begin
								user_stack_pointer <= wr_data[p][15:0];
							end else begin
								interrupt_stack_pointer <= wr_data[p][15:0];
							end
						end
						default: ;
					endcase
				end
			end
		end
	end

	// Instruction pointer: a load (jump) overrides the sequential step
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pc <= RST_LONG;
		end else begin
			if (PC_STEP_EN_I) begin
				pc <= pc + {17'h0_0000, PC_STEP_I};
			end
			for (int p = 0; p < 2; p++) begin
				if (wr_en[p] && wr_sel[p] == SEL_PC) begin
					pc <= wr_data[p][19:0];
				end
			end
		end
	end

	// Flags: ALU results override a plain write of the same bits
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cpu_flags <= RST_FLG;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (wr_en[p] && wr_sel[p] == SEL_FLAGS) begin
					cpu_flags <= wr_data[p][10:0];
				end
			end
			if (ALU_CARRY_EN_I) begin
				cpu_flags[FLG_C] <= ALU_CARRY_I;
			end
			if (ALU_FLAG_EN_I) begin
				cpu_flags[FLG_Z] <= crs_is_zero(ALU_RESULT_I, ALU_SIZE_I);
				cpu_flags[FLG_S] <= crs_is_neg(ALU_RESULT_I, ALU_SIZE_I);
			end
			if (ALU_OVF_EN_I) begin
				cpu_flags[FLG_O] <= ALU_OVF_I;
			end
		end
	end

	// Core read port, one cycle latency
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			EX_RD_DATA_O <= 32'h0000_0000;
		end else begin
			EX_RD_DATA_O <= rd_val(EX_RD_SEL_I);
		end
	end

	// Muxed outputs lag one cycle so they leave from flops
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ACTIVE_SP_O  <= RST_WORD;
			FRAME_BASE_O <= RST_WORD;
		end else begin
			ACTIVE_SP_O  <= cpu_flags[FLG_U] ? user_stack_pointer : interrupt_stack_pointer;
			FRAME_BASE_O <= fbreg[bank];
		end
	end

	// Unmuxed outputs are the storage flops themselves
	assign PC_O          = pc;
	assign VECT_BASE_O   = vector_table_base;
	assign STATIC_BASE_O = sb;
	assign FLAGS_O       = cpu_flags;

	// Checks
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence s_core_wr(logic [4:0] sel);
		EX_WR_EN_I && EX_WR_SEL_I == sel && !apb_wr;
	endsequence

	sequence s_apb_wait;
		PSEL_I && PENABLE_I && !PREADY_O;
	endsequence

	property p_zero_flag;
		ALU_FLAG_EN_I |=> FLAGS_O[FLG_Z] ==
			$past(crs_is_zero(ALU_RESULT_I, ALU_SIZE_I));
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero flag does not match result");

	property p_sign_flag;
		ALU_FLAG_EN_I && ALU_SIZE_I == SIZE_BYTE
			|=> FLAGS_O[FLG_S] == $past(ALU_RESULT_I[7]);
	endproperty
	a_sign_flag: assert property (p_sign_flag)
		else $error("sign flag does not match byte result");

	property p_carry_flag;
		ALU_CARRY_EN_I |=> FLAGS_O[FLG_C] == $past(ALU_CARRY_I);
	endproperty
	a_carry_flag: assert property (p_carry_flag)
		else $error("carry flag not captured");

	property p_ovf_flag;
		ALU_OVF_EN_I ##1 !ALU_OVF_EN_I && !EX_WR_EN_I && !apb_wr
			|=> FLAGS_O[FLG_O] == $past(ALU_OVF_I, 2);
	endproperty
	a_ovf_flag: assert property (p_ovf_flag)
		else $error("overflow flag not held");

	property p_byte_keep;
		s_core_wr(SEL_D0_LOW) |=> cur_d[0][15:8] == $past(cur_d[0][15:8])
			&& cur_d[0][7:0] == $past(EX_WR_DATA_I[7:0]);
	endproperty
	a_byte_keep: assert property (p_byte_keep)
		else $error("low byte write disturbed high byte");

	property p_pair_data;
		s_core_wr(SEL_PAIR_D1) |=>
			{cur_d[3], cur_d[1]} == $past(EX_WR_DATA_I);
	endproperty
	a_pair_data: assert property (p_pair_data)
		else $error("data pair halves not written together");

	property p_pair_addr;
		s_core_wr(SEL_PAIR_A) |=> cur_a[1] == $past(EX_WR_DATA_I[31:16])
			&& cur_a[0] == $past(EX_WR_DATA_I[15:0]);
	endproperty
	a_pair_addr: assert property (p_pair_addr)
		else $error("address pair halves wrong");

	property p_pc_step;
		PC_STEP_EN_I && !(wr_en[0] && wr_sel[0] == SEL_PC)
			&& !(wr_en[1] && wr_sel[1] == SEL_PC)
			|=> PC_O == $past(PC_O) + 20'($past(PC_STEP_I));
	endproperty
	a_pc_step: assert property (p_pc_step)
		else $error("instruction pointer did not advance");

	property p_sp_select;
		s_core_wr(SEL_SP) ##0 cpu_flags[FLG_U]
			|=> user_stack_pointer == $past(EX_WR_DATA_I[15:0])
			##1 (!$past(cpu_flags[FLG_U]) || ACTIVE_SP_O == $past(user_stack_pointer));
	endproperty
	a_sp_select: assert property (p_sp_select)
		else $error("active stack pointer not the user one");

	property p_bank_read;
		EX_RD_SEL_I == SEL_DATA0 |=> EX_RD_DATA_O[15:0] ==
			$past(cpu_flags[FLG_B] ? dreg[1][0] : dreg[0][0]);
	endproperty
	a_bank_read: assert property (p_bank_read)
		else $error("read not steered to selected bank");

	property p_apb_ready;
		s_apb_wait |=> PREADY_O ##1 !PREADY_O;
	endproperty
	a_apb_ready: assert property (p_apb_ready)
		else $error("bus ready not a single pulse after wait");

endmodule // crs_core_regs
`default_nettype wire

/* File: bench/tb_cpu_core_register_set.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_core_register_set;
	import crs_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ex_wr_en = 1'b0;
	logic [4:0]  ex_wr_sel = 5'h00;
	logic [31:0] ex_wr_data = 32'h0000_0000;
	logic [4:0]  ex_rd_sel = 5'h00;
	logic [31:0] ex_rd_data;
	logic        alu_flag_en = 1'b0;
	logic [1:0]  alu_size = 2'h0;
	logic [31:0] alu_result = 32'h0000_0000;
	logic        alu_carry_en = 1'b0;
	logic        alu_carry = 1'b0;
	logic        alu_ovf_en = 1'b0;
	logic        alu_ovf = 1'b0;
	logic        pc_step_en = 1'b0;
	logic [2:0]  pc_step = 3'h0;
	logic [15:0] active_sp;
	logic [19:0] pc;
	logic [19:0] vect;
	logic [15:0] frame;
	logic [15:0] stat;
	logic [10:0] flags;
	int          n_mismatch = 0;
	int          checked = 0;
	logic [31:0] m [0:11];

	crs_core_regs i_crs_core_regs (
		.MCLK_I(mclk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .EX_WR_EN_I(ex_wr_en), .EX_WR_SEL_I(ex_wr_sel),
		.EX_WR_DATA_I(ex_wr_data), .EX_RD_SEL_I(ex_rd_sel),
		.EX_RD_DATA_O(ex_rd_data), .ALU_FLAG_EN_I(alu_flag_en),
		.ALU_SIZE_I(alu_size), .ALU_RESULT_I(alu_result),
		.ALU_CARRY_EN_I(alu_carry_en), .ALU_CARRY_I(alu_carry),
		.ALU_OVF_EN_I(alu_ovf_en), .ALU_OVF_I(alu_ovf),
		.PC_STEP_EN_I(pc_step_en), .PC_STEP_I(pc_step),
		.ACTIVE_SP_O(active_sp), .PC_O(pc), .VECT_BASE_O(vect),
		.FRAME_BASE_O(frame), .STATIC_BASE_O(stat), .FLAGS_O(flags)
	);

	// Free-running core clock
	always #10 mclk = ~mclk;

	// Verdict and end of run, shared with the watchdog
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Register width behind each word select
	function automatic logic [31:0] wmask(input logic [4:0] s);
		if (s == SEL_VECT || s == SEL_PC)
			wmask = 32'h000F_FFFF;
		else if (s == SEL_FLAGS)
			wmask = 32'h0000_07FF;
		else if (s >= SEL_D0_LOW && s <= SEL_D1_HIGH)
			wmask = 32'h0000_00FF;
		else if (s >= SEL_PAIR_D0 && s <= SEL_PAIR_A)
			wmask = 32'hFFFF_FFFF;
		else
			wmask = 32'h0000_FFFF;
	endfunction

	function automatic logic zref(input logic [31:0] r, input logic [1:0] z);
		zref = (z == 2'h0) ? (r[7:0] == 8'h00) :
			(z == 2'h1) ? (r[15:0] == 16'h0000) : (r == 32'h0000_0000);
	endfunction

	function automatic logic nref(input logic [31:0] r, input logic [1:0] z);
		nref = (z == 2'h0) ? r[7] : (z == 2'h1) ? r[15] : r[31];
	endfunction

	// APB transfer; ready, data and error are taken at the completing edge
	task automatic apb(input logic w, input logic [4:0] s,
		input logic [31:0] d, input logic [3:0] st,
		output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {5'h00, s, 2'h0};
		pwdata <= d;
		pstrb <= st;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] s, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, s, d, 4'hF, r, e);
	endtask

	task automatic rdc(input logic [4:0] s, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, s, 32'h0000_0000, 4'h0, r, e);
		chk(r, exp);
		chk(32'(e), 32'h0000_0000);
	endtask

	// Stack pointer output lags the flag by one registered stage
	task automatic sp_chk(input logic [15:0] exp);
		@(posedge mclk);
		@(negedge mclk);
		chk(32'(active_sp), 32'(exp));
		rdc(SEL_SP, 32'(exp));
	endtask

	initial begin
		#(20 * 20000);
		n_mismatch++;
		final_report();
	end

	initial begin
		logic [31:0] d;
		logic [31:0] r;
		logic        e;
		logic        c;
		logic        o;
		logic [4:0]  up [0:2];
		logic [4:0]  lo [0:2];
		up = '{SEL_DATA2, SEL_DATA3, SEL_ADDR1};
		lo = '{SEL_DATA0, SEL_DATA1, SEL_ADDR0};
		c = 1'b0;
		o = 1'b0;
		d = $urandom(32'hf71c129b);
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		// Zero after reset, then random write and masked read-back
		for (int s = 0; s < 12; s++) begin
			rdc(5'(s), 32'h0000_0000);
			m[s] = $urandom() & wmask(5'(s));
			wr(5'(s), $urandom() & 32'hFFF0_0000 | m[s]);
			rdc(5'(s), m[s]);
		end
		@(negedge mclk);
		chk(32'(vect), m[7]);
		chk(32'(stat), m[11]);
		chk(32'(frame), m[6]);
		$display("test words done");
		// Byte halves of data words 0 and 1
		for (int k = 0; k < 2; k++) begin
			d = $urandom();
			wr(5'(SEL_D0_LOW + 2 * k), d);
			m[k][7:0] = d[7:0];
			rdc(5'(k), m[k]);
			wr(5'(SEL_D0_HIGH + 2 * k), {d[7:0], d[15:8]});
			m[k][15:8] = d[15:8];
			rdc(5'(k), m[k]);
			rdc(5'(SEL_D0_HIGH + 2 * k), 32'(m[k][15:8]));
		end
		// Lane strobe merges with current contents
		apb(1'b1, SEL_DATA0, 32'h0000_A55A, 4'h2, r, e);
		m[0][15:8] = 8'hA5;
		rdc(SEL_DATA0, m[0]);
		$display("test bytes done");
		// Wide pairs update both halves together
		for (int k = 0; k < 3; k++) begin
			d = $urandom();
			wr(5'(SEL_PAIR_D0 + k), d);
			rdc(up[k], 32'(d[31:16]));
			rdc(lo[k], 32'(d[15:0]));
			rdc(5'(SEL_PAIR_D0 + k), d);
		end
		m[0] = 32'(d[15:0] ^ 16'h1234);
		wr(SEL_DATA0, m[0]);
		$display("test pairs done");
		// Stack select by the flag
		sp_chk(m[10][15:0]);
		wr(SEL_FLAGS, 32'h0000_0080);
		sp_chk(m[9][15:0]);
		wr(SEL_FLAGS, 32'h0000_0000);
		sp_chk(m[10][15:0]);
		$display("test stack done");
		// Bank 1 is separate storage, bank 0 survives the switch
		wr(SEL_FLAGS, 32'h0000_0010);
		rdc(SEL_DATA0, 32'h0000_0000);
		@(posedge mclk);
		@(negedge mclk);
		chk(32'(frame), 32'h0000_0000);
		wr(SEL_DATA0, 32'h0000_BEEF);
		rdc(SEL_DATA0, 32'h0000_BEEF);
		wr(SEL_FLAGS, 32'h0000_0000);
		rdc(SEL_DATA0, m[0]);
		$display("test bank done");
		// Flags from the ALU; boundary results first, then random
		for (int i = 0; i < 40; i++) begin
			d = (i < 4) ? (32'h0000_0080 << (8 * i)) >> 8 : $urandom();
			@(posedge mclk);
			alu_flag_en <= 1'b1;
			alu_result <= d;
			alu_size <= 2'(i < 4 ? i : $urandom());
			alu_carry_en <= 1'(i < 4 ? 1 : $urandom());
			alu_carry <= 1'($urandom());
			alu_ovf_en <= 1'(i < 4 ? 1 : $urandom());
			alu_ovf <= 1'($urandom());
			@(posedge mclk);
			alu_flag_en <= 1'b0;
			alu_carry_en <= 1'b0;
			alu_ovf_en <= 1'b0;
			if (alu_carry_en)
				c = alu_carry;
			if (alu_ovf_en)
				o = alu_ovf;
			@(negedge mclk);
			chk(32'(flags[FLG_Z]), 32'(zref(d, alu_size)));
			chk(32'(flags[FLG_S]), 32'(nref(d, alu_size)));
			chk(32'(flags[FLG_C]), 32'(c));
			chk(32'(flags[FLG_O]), 32'(o));
		end
		$display("test flags done");
		// Core write port over every select, read back one cycle later
		for (int i = 0; i < 42; i++) begin
			d = $urandom();
			// Debug flag kept clear; user pointer chosen for the alias
			if (i % 21 == SEL_FLAGS) begin
				d[FLG_D] = 1'b0;
				d[FLG_U] = 1'b1;
			end
			@(posedge mclk);
			ex_wr_en <= 1'b1;
			ex_wr_sel <= 5'(i % 21);
			ex_wr_data <= d;
			ex_rd_sel <= 5'(i % 21);
			@(posedge mclk);
			ex_wr_en <= 1'b0;
			@(posedge mclk);
			@(negedge mclk);
			chk(ex_rd_data, d & wmask(5'(i % 21)));
		end
		$display("test core port done");
		// Instruction pointer step wraps at 20 bits
		wr(SEL_PC, 32'h000F_FFFE);
		@(posedge mclk);
		pc_step_en <= 1'b1;
		pc_step <= 3'h3;
		@(posedge mclk);
		pc_step_en <= 1'b0;
		@(negedge mclk);
		chk(32'(pc), 32'h0000_0001);
		// Unmapped select is refused with an error
		apb(1'b0, 5'h15, 32'h0000_0000, 4'hF, r, e);
		chk(32'(e), 32'h0000_0001);
		chk(r, 32'h0000_0000);
		$display("test pc and unmapped done");
		final_report();
	end

endmodule // tb_cpu_core_register_set
`default_nettype wire
